// >>> rtl/fid_pkg.sv
// constants, field layouts and types for the fixed-length instruction field decoder
// assumes the fetch stage tells the format, operand role, operand size and immediate kind
package fid_pkg;
    localparam int unsigned FID_IW = 16;
    // field positions within the instruction word
    localparam int unsigned FID_N_HI = 11;
    localparam int unsigned FID_N_LO = 8;
    localparam int unsigned FID_M_HI = 7;
    localparam int unsigned FID_M_LO = 4;
    localparam int unsigned FID_D4_HI = 3;
    localparam int unsigned FID_D8_HI = 7;
    localparam int unsigned FID_D12_HI = 11;
    // operand field masks per format, cleared out of the opcode
    localparam logic [15:0] FID_MASK_NONE = 16'h0000;
    localparam logic [15:0] FID_MASK_N = 16'h0f00;
    localparam logic [15:0] FID_MASK_NM = 16'h0ff0;
    localparam logic [15:0] FID_MASK_MD = 16'h00ff;
    localparam logic [15:0] FID_MASK_NMD = 16'h0fff;
    localparam logic [15:0] FID_MASK_D = 16'h00ff;
    localparam logic [15:0] FID_MASK_D12 = 16'h0fff;
    localparam logic [15:0] FID_MASK_ND8 = 16'h0fff;
    localparam logic [3:0] FID_REG_ZERO = 4'h0;
    localparam logic [31:0] FID_ZERO32 = 32'h0000_0000;
    // operand roles within each format
    localparam logic [2:0] FID_N_DIRECT = 3'h0;
    localparam logic [2:0] FID_N_CTRL_DIRECT = 3'h1;
    localparam logic [2:0] FID_N_CTRL_PREDEC = 3'h2;
    localparam logic [2:0] FID_M_CTRL_DIRECT = 3'h0;
    localparam logic [2:0] FID_M_CTRL_POSTINC = 3'h1;
    localparam logic [2:0] FID_M_JUMP = 3'h2;
    localparam logic [2:0] FID_M_BRANCH_REG = 3'h3;
    localparam logic [2:0] FID_NM_DIRECT = 3'h0;
    localparam logic [2:0] FID_NM_IND = 3'h1;
    localparam logic [2:0] FID_NM_MAC = 3'h2;
    localparam logic [2:0] FID_NM_POSTINC = 3'h3;
    localparam logic [2:0] FID_NM_PREDEC = 3'h4;
    localparam logic [2:0] FID_NM_INDEXED = 3'h5;
    localparam logic [2:0] FID_NMD_STORE = 3'h0;
    localparam logic [2:0] FID_NMD_LOAD = 3'h1;
    localparam logic [2:0] FID_D_GBR_LOAD = 3'h0;
    localparam logic [2:0] FID_D_GBR_STORE = 3'h1;
    localparam logic [2:0] FID_D_MOVE_EA = 3'h2;
    localparam logic [2:0] FID_D_COND_BRANCH = 3'h3;
    localparam logic [2:0] FID_I_GBR_INDEXED = 3'h0;
    localparam logic [2:0] FID_I_R0 = 3'h1;
    localparam logic [2:0] FID_I_TRAP = 3'h2;

    typedef enum logic [3:0] {
        FID_FMT_ZERO, FID_FMT_N, FID_FMT_M, FID_FMT_NM, FID_FMT_MD, FID_FMT_ND4,
        FID_FMT_NMD, FID_FMT_D, FID_FMT_D12, FID_FMT_ND8, FID_FMT_I, FID_FMT_NI
    } fid_fmt_e;

    typedef enum logic [3:0] {
        FID_AM_NONE, FID_AM_DIRECT, FID_AM_IND, FID_AM_POSTINC, FID_AM_PREDEC,
        FID_AM_IDX_IND, FID_AM_DISP_IND, FID_AM_GBR_DISP, FID_AM_IDX_GBR,
        FID_AM_PC_DISP, FID_AM_PC_REL, FID_AM_PC_REG, FID_AM_CTRL, FID_AM_ACCUM, FID_AM_IMM
    } fid_mode_e;

    typedef enum logic [1:0] {FID_SZ_BYTE, FID_SZ_WORD, FID_SZ_LONG} fid_size_e;
    typedef enum logic [1:0] {FID_EXT_SIGN, FID_EXT_ZERO, FID_EXT_TRAP} fid_ext_e;

    typedef struct packed {
        logic vld;
        logic illegal;
        logic [15:0] opcode;
        logic [3:0] src_reg;
        logic src_reg_vld;
        logic [3:0] dst_reg;
        logic dst_reg_vld;
        fid_mode_e src_mode;
        fid_mode_e dst_mode;
        logic [31:0] disp;
        logic disp_vld;
        logic [31:0] imm;
        logic imm_vld;
    } fid_state_s;

    localparam fid_state_s FID_STATE_RST = '{
        vld: 1'b0, illegal: 1'b0, opcode: 16'h0000, src_reg: 4'h0, src_reg_vld: 1'b0,
        dst_reg: 4'h0, dst_reg_vld: 1'b0, src_mode: FID_AM_NONE, dst_mode: FID_AM_NONE,
        disp: 32'h0000_0000, disp_vld: 1'b0, imm: 32'h0000_0000, imm_vld: 1'b0};
endpackage

// >>> rtl/fid_decoder.sv
// fixed-length instruction field decoder: splits one 16-bit word into operand fields
// assumes fetch supplies the format, operand role, operand size and immediate kind with the word
// Notes on behaviour
// - every instruction is one 16-bit word, bits 15..0, and the format supplied by fetch picks the operand fields.
// - single-destination format: bits 11..8 are the destination, direct or pre-decrement for a control store.
// - single-source format: bits 11..8 are the source, direct, post-increment, jump target or branch offset.
// - two-register format: bits 11..8 destination, 7..4 source, in direct, indirect, inc, dec or indexed modes.
// - multiply-accumulate takes bits 7..4 as a post-increment source, gives bits 11..8 the accumulator mode, and writes the accumulator pair.
// - source with 4-bit displacement: base in bits 7..4, displacement in 3..0, register zero is destination.
// - destination with 4-bit displacement: base in bits 7..4, displacement in 3..0, register zero is source.
// - three-field format: bits 11..8 and 7..4 are registers, 3..0 displacement, either side displaced.
// - 8-bit displacement format: global-base memory with register zero, address move, or conditional branch.
// - 12-bit displacement format: bits 11..0 are a pc-relative displacement for an unconditional branch.
// - register with 8-bit displacement: bits 11..8 destination, bits 7..0 pc-relative load displacement.
// - 8-bit immediate format: bits 7..0 immediate into indexed global-base memory, register zero or trap.
// - register with immediate: bits 11..8 direct destination, bits 7..0 immediate source.
// - 8-bit immediates sign-extend for move, add, compare, zero-extend for logic, and times four for trap.
// - displacements scale by one, two or four for byte, word or longword operands.
`timescale 1ns/10ps
module fid_decoder
    import fid_pkg::*;
(
    // clock and reset
    input logic clk,
    input logic rstn,
    // from fetch
    input logic instr_valid,
    input logic [15:0] instr_word,
    input fid_fmt_e instr_format,
    input logic [2:0] operand_role,
    input fid_size_e operand_size,
    input fid_ext_e imm_kind,
    // to execution datapath
    output logic dec_valid,
    output logic dec_illegal,
    output logic [15:0] opcode,
    output logic [3:0] src_reg,
    output logic src_reg_vld,
    output logic [3:0] dst_reg,
    output logic dst_reg_vld,
    output fid_mode_e src_mode,
    output fid_mode_e dst_mode,
    output logic [31:0] disp,
    output logic disp_vld,
    output logic [31:0] imm,
    output logic imm_vld
);

    fid_state_s st_r, st_nxt;

    function automatic logic [31:0] fid_scale(input logic [31:0] d, input fid_size_e sz);
        return (sz == FID_SZ_LONG) ? {d[29:0], 2'b00} : (sz == FID_SZ_WORD) ? {d[30:0], 1'b0} : d;
    endfunction

    function automatic logic [31:0] fid_ext_imm(input logic [7:0] i, input fid_ext_e k);
        return (k == FID_EXT_SIGN) ? {{24{i[7]}}, i} : (k == FID_EXT_TRAP) ? {22'h0, i, 2'b00} : {24'h0, i};
    endfunction

    logic [3:0] f_n, f_m;
    logic [31:0] d4_u, d8_u, d8_s, d12_s;
    logic [15:0] mask;

    always_comb begin
        f_n = instr_word[FID_N_HI:FID_N_LO];
        f_m = instr_word[FID_M_HI:FID_M_LO];
        d4_u = {28'h000_0000, instr_word[FID_D4_HI:0]};
        d8_u = {24'h00_0000, instr_word[FID_D8_HI:0]};
        d8_s = {{24{instr_word[FID_D8_HI]}}, instr_word[FID_D8_HI:0]};
        // branch offsets reach backwards, so they are signed
        d12_s = {{20{instr_word[FID_D12_HI]}}, instr_word[FID_D12_HI:0]};
        mask = FID_MASK_NONE;
        st_nxt = FID_STATE_RST;
        st_nxt.vld = instr_valid;
        if (instr_valid) begin
            unique case (instr_format)
                FID_FMT_ZERO: begin
                    mask = FID_MASK_NONE;
                end
                FID_FMT_N: begin
                    mask = FID_MASK_N;
                    st_nxt.dst_reg = f_n;
                    st_nxt.dst_reg_vld = 1'b1;
                    if (operand_role == FID_N_DIRECT) begin
                        st_nxt.dst_mode = FID_AM_DIRECT;
                    end else if (operand_role == FID_N_CTRL_DIRECT) begin
                        st_nxt.src_mode = FID_AM_CTRL;
                        st_nxt.dst_mode = FID_AM_DIRECT;
                    end else if (operand_role == FID_N_CTRL_PREDEC) begin
                        st_nxt.src_mode = FID_AM_CTRL;
                        st_nxt.dst_mode = FID_AM_PREDEC;
                    end else begin
                        st_nxt.illegal = 1'b1;
                    end
                end
                FID_FMT_M: begin
                    mask = FID_MASK_N;
                    st_nxt.src_reg = f_n;
                    st_nxt.src_reg_vld = 1'b1;
                    if (operand_role == FID_M_CTRL_DIRECT) begin
                        st_nxt.src_mode = FID_AM_DIRECT;
                        st_nxt.dst_mode = FID_AM_CTRL;
                    end else if (operand_role == FID_M_CTRL_POSTINC) begin
                        st_nxt.src_mode = FID_AM_POSTINC;
                        st_nxt.dst_mode = FID_AM_CTRL;
                    end else if (operand_role == FID_M_JUMP) begin
                        st_nxt.src_mode = FID_AM_IND;
                    end else if (operand_role == FID_M_BRANCH_REG) begin
                        st_nxt.src_mode = FID_AM_PC_REG;
                    end else begin
                        st_nxt.illegal = 1'b1;
                    end
                end
                FID_FMT_NM: begin
                    mask = FID_MASK_NM;
                    st_nxt.dst_reg = f_n;
                    st_nxt.src_reg = f_m;
                    st_nxt.dst_reg_vld = 1'b1;
                    st_nxt.src_reg_vld = 1'b1;
                    st_nxt.src_mode = FID_AM_DIRECT;
                    st_nxt.dst_mode = FID_AM_DIRECT;
                    if (operand_role == FID_NM_IND) begin
                        st_nxt.src_mode = FID_AM_IND;
                        st_nxt.dst_mode = FID_AM_IND;
                    end else if (operand_role == FID_NM_MAC) begin
                        // the n field stays the destination register, marked with the accumulator mode
                        st_nxt.src_mode = FID_AM_POSTINC;
                        st_nxt.dst_mode = FID_AM_ACCUM;
                    end else if (operand_role == FID_NM_POSTINC) begin
                        st_nxt.src_mode = FID_AM_POSTINC;
                    end else if (operand_role == FID_NM_PREDEC) begin
                        st_nxt.dst_mode = FID_AM_PREDEC;
                    end else if (operand_role == FID_NM_INDEXED) begin
                        st_nxt.dst_mode = FID_AM_IDX_IND;
                    end else if (operand_role != FID_NM_DIRECT) begin
                        st_nxt.illegal = 1'b1;
                    end
                end
                FID_FMT_MD: begin
                    mask = FID_MASK_MD;
                    st_nxt.src_reg = f_m;
                    st_nxt.src_reg_vld = 1'b1;
                    st_nxt.src_mode = FID_AM_DISP_IND;
                    st_nxt.dst_reg = FID_REG_ZERO;
                    st_nxt.dst_reg_vld = 1'b1;
                    st_nxt.dst_mode = FID_AM_DIRECT;
                    st_nxt.disp = fid_scale(d4_u, operand_size);
                    st_nxt.disp_vld = 1'b1;
                end
                FID_FMT_ND4: begin
                    mask = FID_MASK_MD;
                    st_nxt.dst_reg = f_m;
                    st_nxt.dst_reg_vld = 1'b1;
                    st_nxt.dst_mode = FID_AM_DISP_IND;
                    st_nxt.src_reg = FID_REG_ZERO;
                    st_nxt.src_reg_vld = 1'b1;
                    st_nxt.src_mode = FID_AM_DIRECT;
                    st_nxt.disp = fid_scale(d4_u, operand_size);
                    st_nxt.disp_vld = 1'b1;
                end
                FID_FMT_NMD: begin
                    mask = FID_MASK_NMD;
                    st_nxt.dst_reg = f_n;
                    st_nxt.src_reg = f_m;
                    st_nxt.dst_reg_vld = 1'b1;
                    st_nxt.src_reg_vld = 1'b1;
                    st_nxt.disp = fid_scale(d4_u, operand_size);
                    st_nxt.disp_vld = 1'b1;
                    if (operand_role == FID_NMD_STORE) begin
                        st_nxt.src_mode = FID_AM_DIRECT;
                        st_nxt.dst_mode = FID_AM_DISP_IND;
                    end else if (operand_role == FID_NMD_LOAD) begin
                        st_nxt.src_mode = FID_AM_DISP_IND;
                        st_nxt.dst_mode = FID_AM_DIRECT;
                    end else begin
                        st_nxt.illegal = 1'b1;
                    end
                end
                FID_FMT_D: begin
                    mask = FID_MASK_D;
                    st_nxt.disp = fid_scale(d8_u, operand_size);
                    st_nxt.disp_vld = 1'b1;
                    if (operand_role == FID_D_GBR_LOAD) begin
                        st_nxt.src_mode = FID_AM_GBR_DISP;
                        st_nxt.dst_reg_vld = 1'b1;
                        st_nxt.dst_mode = FID_AM_DIRECT;
                    end else if (operand_role == FID_D_GBR_STORE) begin
                        st_nxt.src_reg_vld = 1'b1;
                        st_nxt.src_mode = FID_AM_DIRECT;
                        st_nxt.dst_mode = FID_AM_GBR_DISP;
                    end else if (operand_role == FID_D_MOVE_EA) begin
                        st_nxt.src_mode = FID_AM_PC_DISP;
                        st_nxt.dst_reg_vld = 1'b1;
                        st_nxt.dst_mode = FID_AM_DIRECT;
                    end else if (operand_role == FID_D_COND_BRANCH) begin
                        st_nxt.src_mode = FID_AM_PC_REL;
                        st_nxt.disp = fid_scale(d8_s, operand_size);
                    end else begin
                        st_nxt.illegal = 1'b1;
                    end
                end
                FID_FMT_D12: begin
                    mask = FID_MASK_D12;
                    st_nxt.src_mode = FID_AM_PC_REL;
                    st_nxt.disp = fid_scale(d12_s, operand_size);
                    st_nxt.disp_vld = 1'b1;
                end
                FID_FMT_ND8: begin
                    mask = FID_MASK_ND8;
                    st_nxt.dst_reg = f_n;
                    st_nxt.dst_reg_vld = 1'b1;
                    st_nxt.dst_mode = FID_AM_DIRECT;
                    st_nxt.src_mode = FID_AM_PC_DISP;
                    st_nxt.disp = fid_scale(d8_u, operand_size);
                    st_nxt.disp_vld = 1'b1;
                end
                FID_FMT_I: begin
                    mask = FID_MASK_D;
                    st_nxt.src_mode = FID_AM_IMM;
                    st_nxt.imm = fid_ext_imm(instr_word[FID_D8_HI:0], imm_kind);
                    st_nxt.imm_vld = 1'b1;
                    if (operand_role == FID_I_GBR_INDEXED) begin
                        st_nxt.dst_mode = FID_AM_IDX_GBR;
                    end else if (operand_role == FID_I_R0) begin
                        st_nxt.dst_reg_vld = 1'b1;
                        st_nxt.dst_mode = FID_AM_DIRECT;
                    end else if (operand_role != FID_I_TRAP) begin
                        st_nxt.illegal = 1'b1;
                    end
                end
                FID_FMT_NI: begin
                    mask = FID_MASK_ND8;
                    st_nxt.dst_reg = f_n;
                    st_nxt.dst_reg_vld = 1'b1;
                    st_nxt.dst_mode = FID_AM_DIRECT;
                    st_nxt.src_mode = FID_AM_IMM;
                    st_nxt.imm = fid_ext_imm(instr_word[FID_D8_HI:0], imm_kind);
                    st_nxt.imm_vld = 1'b1;
                end
                default: begin
                    st_nxt.illegal = 1'b1;
                end
            endcase
            // an illegal role leaves no fields for execution to act on
            if (st_nxt.illegal) begin
                st_nxt = FID_STATE_RST;
                st_nxt.vld = 1'b1;
                st_nxt.illegal = 1'b1;
                mask = FID_MASK_NONE;
            end
            st_nxt.opcode = instr_word & ~mask;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            st_r <= FID_STATE_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign {dec_valid, dec_illegal, opcode, src_reg, src_reg_vld, dst_reg, dst_reg_vld} = {st_r.vld, st_r.illegal,
        st_r.opcode, st_r.src_reg, st_r.src_reg_vld, st_r.dst_reg, st_r.dst_reg_vld};
    assign src_mode = st_r.src_mode;
    assign dst_mode = st_r.dst_mode;
    assign {disp, disp_vld, imm, imm_vld} = {st_r.disp, st_r.disp_vld, st_r.imm, st_r.imm_vld};

    sequence s_fmt_in(fid_fmt_e f);
        instr_valid && instr_format == f;
    endsequence

    property p_zero_fmt;
        @(posedge clk) disable iff (!rstn)
        s_fmt_in(FID_FMT_ZERO) |=> opcode == $past(instr_word)
            && !src_reg_vld && !dst_reg_vld && !disp_vld && !imm_vld;
    endproperty
    a_zero_fmt: assert property (p_zero_fmt) else $error("operand-less word not passed whole");

    property p_n_dst;
        @(posedge clk) disable iff (!rstn)
        s_fmt_in(FID_FMT_N) ##1 !dec_illegal |-> dst_reg == $past(instr_word[11:8]) && opcode[11:8] == 4'h0;
    endproperty
    a_n_dst: assert property (p_n_dst) else $error("destination field wrong in n format");

    property p_m_src;
        @(posedge clk) disable iff (!rstn)
        s_fmt_in(FID_FMT_M) ##0 operand_role == FID_M_CTRL_POSTINC |=> src_reg == $past(instr_word[11:8])
            && src_mode == FID_AM_POSTINC && dst_mode == FID_AM_CTRL;
    endproperty
    a_m_src: assert property (p_m_src) else $error("source field wrong in m format");

    property p_nm_fields;
        @(posedge clk) disable iff (!rstn)
        s_fmt_in(FID_FMT_NM) ##0 operand_role == FID_NM_PREDEC |=> dst_reg == $past(instr_word[11:8])
            && src_reg == $past(instr_word[7:4]) && dst_mode == FID_AM_PREDEC;
    endproperty
    a_nm_fields: assert property (p_nm_fields) else $error("register fields wrong in nm format");

    property p_mac;
        @(posedge clk) disable iff (!rstn)
        s_fmt_in(FID_FMT_NM) ##0 operand_role == FID_NM_MAC |=> dst_mode == FID_AM_ACCUM
            && src_mode == FID_AM_POSTINC;
    endproperty
    a_mac: assert property (p_mac) else $error("multiply-accumulate modes wrong");

    property p_md;
        @(posedge clk) disable iff (!rstn)
        s_fmt_in(FID_FMT_MD) ##0 operand_size == FID_SZ_LONG |=> dst_reg == FID_REG_ZERO
            && src_reg == $past(instr_word[7:4]) && disp == {26'h000_0000, $past(instr_word[3:0]), 2'b00};
    endproperty
    a_md: assert property (p_md) else $error("displaced source decode wrong");

    property p_nd4;
        @(posedge clk) disable iff (!rstn)
        s_fmt_in(FID_FMT_ND4) |=> src_reg == FID_REG_ZERO && dst_mode == FID_AM_DISP_IND
            && dst_reg == $past(instr_word[7:4]);
    endproperty
    a_nd4: assert property (p_nd4) else $error("displaced destination decode wrong");

    property p_d12;
        @(posedge clk) disable iff (!rstn)
        s_fmt_in(FID_FMT_D12) ##0 operand_size == FID_SZ_WORD |=> disp[12:1] == $past(instr_word[11:0])
            && disp[0] == 1'b0 && disp[31] == disp[12];
    endproperty
    a_d12: assert property (p_d12) else $error("12-bit branch displacement wrong");

    property p_trap;
        @(posedge clk) disable iff (!rstn)
        s_fmt_in(FID_FMT_I) ##0 (imm_kind == FID_EXT_TRAP && operand_role <= FID_I_TRAP)
            |=> imm == {22'h00_0000, $past(instr_word[7:0]), 2'b00};
    endproperty
    a_trap: assert property (p_trap) else $error("trap immediate not scaled by four");

    property p_ni_sign;
        @(posedge clk) disable iff (!rstn)
        s_fmt_in(FID_FMT_NI) ##0 imm_kind == FID_EXT_SIGN |=> dst_reg == $past(instr_word[11:8])
            && imm == {{24{$past(instr_word[7])}}, $past(instr_word[7:0])};
    endproperty
    a_ni_sign: assert property (p_ni_sign) else $error("register immediate decode wrong");

endmodule

// >>> bench/fid_exec_model.sv
// execution-side model: gathers the decoded fields into one record
// assumes every decoder output comes straight from a flip-flop
`timescale 1ns/10ps
module fid_exec_model
    import fid_pkg::*;
(
    // decoded fields
    input logic dec_valid,
    input logic dec_illegal,
    input logic [15:0] opcode,
    input logic [3:0] src_reg,
    input logic src_reg_vld,
    input logic [3:0] dst_reg,
    input logic dst_reg_vld,
    input fid_mode_e src_mode,
    input fid_mode_e dst_mode,
    input logic [31:0] disp,
    input logic disp_vld,
    input logic [31:0] imm,
    input logic imm_vld,
    // record for the bench
    output fid_state_s got
);
    // whole record compared at once, so a stray field cannot hide
    assign got = '{dec_valid, dec_illegal, opcode, src_reg, src_reg_vld, dst_reg, dst_reg_vld,
                   src_mode, dst_mode, disp, disp_vld, imm, imm_vld};
endmodule

// >>> bench/test_fixed_length_instr_field_decoder.sv
// testbench: feeds words as fetch would and checks every decoded record
// assumes one clock, synchronous active-low reset, one-cycle answer
`timescale 1ns/10ps
module test_fixed_length_instr_field_decoder;
    import fid_pkg::*;
    logic clk = 1'b0, rstn = 1'b0, instr_valid = 1'b0;
    logic [15:0] instr_word = 16'h0000;
    fid_fmt_e instr_format = FID_FMT_ZERO;
    logic [2:0] operand_role = 3'h0;
    fid_size_e operand_size = FID_SZ_BYTE;
    fid_ext_e imm_kind = FID_EXT_SIGN;
    logic dec_valid, dec_illegal, src_reg_vld, dst_reg_vld, disp_vld, imm_vld;
    logic [15:0] opcode;
    logic [3:0] src_reg, dst_reg;
    fid_mode_e src_mode, dst_mode;
    logic [31:0] disp, imm, lf = 32'h0000_0389;
    fid_state_s got;
    fid_state_s q[$];
    int n_errors = 0, comparisons = 0, cyc = 0;
    always #25 clk = ~clk;
    fid_decoder uut (.clk, .rstn, .instr_valid, .instr_word, .instr_format, .operand_role, .operand_size,
        .imm_kind, .dec_valid, .dec_illegal, .opcode, .src_reg, .src_reg_vld, .dst_reg, .dst_reg_vld,
        .src_mode, .dst_mode, .disp, .disp_vld, .imm, .imm_vld);
    fid_exec_model ex (.dec_valid, .dec_illegal, .opcode, .src_reg, .src_reg_vld, .dst_reg, .dst_reg_vld,
        .src_mode, .dst_mode, .disp, .disp_vld, .imm, .imm_vld, .got);
    function automatic logic [31:0] lfsr_next(logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function automatic fid_state_s expect_of(fid_fmt_e f, logic [2:0] r, fid_size_e s, fid_ext_e k,
                                              logic [15:0] w);
        fid_state_s e;
        logic [31:0] sc, iv;
        e = FID_STATE_RST;
        e.vld = 1'b1;
        sc = (s == FID_SZ_BYTE) ? 32'h1 : (s == FID_SZ_WORD) ? 32'h2 : 32'h4;
        iv = (k == FID_EXT_SIGN) ? {{24{w[7]}}, w[7:0]} : (k == FID_EXT_TRAP) ? {22'h0, w[7:0], 2'h0} : {24'h0, w[7:0]};
        case (f)
            FID_FMT_ZERO: e.opcode = w;
            FID_FMT_N, FID_FMT_M: begin
                e.opcode = w & 16'hf0ff;
                if (f == FID_FMT_N) begin
                    {e.dst_reg, e.dst_reg_vld} = {w[11:8], 1'b1};
                    e.src_mode = FID_AM_CTRL;
                    e.dst_mode = FID_AM_PREDEC;
                end else begin
                    {e.src_reg, e.src_reg_vld} = {w[11:8], 1'b1};
                    e.src_mode = FID_AM_POSTINC;
                    e.dst_mode = FID_AM_CTRL;
                end
            end
            FID_FMT_NM: begin
                e.opcode = w & 16'hf00f;
                {e.dst_reg, e.src_reg, e.dst_reg_vld, e.src_reg_vld} = {w[11:8], w[7:4], 2'b11};
                e.dst_mode = (r == FID_NM_MAC) ? FID_AM_ACCUM : (r == FID_NM_PREDEC) ? FID_AM_PREDEC : FID_AM_DIRECT;
                e.src_mode = (r == FID_NM_MAC) ? FID_AM_POSTINC : FID_AM_DIRECT;
            end
            FID_FMT_MD, FID_FMT_ND4: begin
                e.opcode = w & 16'hff00;
                {e.src_reg_vld, e.dst_reg_vld, e.disp_vld} = 3'b111;
                e.src_reg = (f == FID_FMT_MD) ? w[7:4] : 4'h0;
                e.dst_reg = (f == FID_FMT_MD) ? 4'h0 : w[7:4];
                e.src_mode = (f == FID_FMT_MD) ? FID_AM_DISP_IND : FID_AM_DIRECT;
                e.dst_mode = (f == FID_FMT_MD) ? FID_AM_DIRECT : FID_AM_DISP_IND;
                e.disp = {28'h0, w[3:0]} * sc;
            end
            FID_FMT_NMD, FID_FMT_ND8: begin
                e.opcode = w & 16'hf000;
                {e.dst_reg, e.dst_reg_vld, e.disp_vld} = {w[11:8], 2'b11};
                {e.src_reg, e.src_reg_vld} = (f == FID_FMT_NMD) ? {w[7:4], 1'b1} : 5'h00;
                e.src_mode = (f == FID_FMT_NMD) ? FID_AM_DISP_IND : FID_AM_PC_DISP;
                e.dst_mode = FID_AM_DIRECT;
                e.disp = ((f == FID_FMT_NMD) ? {28'h0, w[3:0]} : {24'h0, w[7:0]}) * sc;
            end
            FID_FMT_D, FID_FMT_D12: begin
                e.opcode = w & ((f == FID_FMT_D) ? 16'hff00 : 16'hf000);
                e.src_mode = FID_AM_PC_REL;
                e.disp = ((f == FID_FMT_D) ? {{24{w[7]}}, w[7:0]} : {{20{w[11]}}, w[11:0]}) * sc;
                e.disp_vld = 1'b1;
            end
            default: begin
                e.opcode = w & ((f == FID_FMT_I) ? 16'hff00 : 16'hf000);
                e.src_mode = FID_AM_IMM;
                e.imm = iv;
                e.imm_vld = 1'b1;
                if (f == FID_FMT_NI) begin
                    {e.dst_reg, e.dst_reg_vld} = {w[11:8], 1'b1};
                    e.dst_mode = FID_AM_DIRECT;
                end
            end
        endcase
        // bad format code or role: only the raw word survives
        if (f > FID_FMT_NI || (f == FID_FMT_NM && r > FID_NM_INDEXED)) begin
            e = FID_STATE_RST;
            {e.vld, e.illegal, e.opcode} = {2'b11, w};
        end
        return e;
    endfunction
    task automatic chk(fid_state_s g, fid_state_s e);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic stop_test();
        if (q.size() != 0) begin
            n_errors++;
            $display("CHECK FAILED %0t %0d results never appeared", $time, q.size());
        end
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // results land on the rising edge, so the falling edge sees them settled
    always @(negedge clk) begin
        cyc++;
        if (rstn && got.vld === 1'b1 && q.size() > 0) begin
            chk(got, q.pop_front());
        end else if (rstn) begin
            chk(got, FID_STATE_RST);
        end
        if (cyc > 500) begin
            n_errors++;
            $display("CHECK FAILED %0t timeout", $time);
            stop_test();
        end
    end
    initial begin
        fid_fmt_e tf[16];
        logic [2:0] tr[16];
        tf = '{FID_FMT_ZERO, FID_FMT_NM, FID_FMT_NM, FID_FMT_NM, FID_FMT_MD, FID_FMT_D12, FID_FMT_NI, FID_FMT_I,
               fid_fmt_e'(4'hd), FID_FMT_N, FID_FMT_M, FID_FMT_NM, FID_FMT_ND4, FID_FMT_NMD, FID_FMT_D, FID_FMT_ND8};
        tr = '{3'h0, FID_NM_DIRECT, FID_NM_MAC, 3'h7, 3'h0, 3'h0, 3'h0, FID_I_TRAP, 3'h0, FID_N_CTRL_PREDEC,
               FID_M_CTRL_POSTINC, FID_NM_PREDEC, 3'h0, FID_NMD_LOAD, FID_D_COND_BRANCH, 3'h0};
        repeat (4) @(negedge clk);
        rstn = 1'b1;
        // back to back, every format in the table, random words, sizes and kinds
        for (int i = 0; i < 48; i++) begin
            lf = lfsr_next(lf);
            instr_valid = 1'b1;
            instr_word = lf[15:0];
            instr_format = tf[i % 16];
            operand_role = tr[i % 16];
            operand_size = fid_size_e'(lf[17:16] % 2'd3);
            imm_kind = fid_ext_e'(lf[19:18] % 2'd3);
            q.push_back(expect_of(instr_format, operand_role, operand_size, imm_kind,
                                  instr_word));
            @(negedge clk);
        end
        instr_valid = 1'b0;
        repeat (3) @(negedge clk);
        $display("test decode sequence done");
        stop_test();
    end
endmodule
